// *** verilog/xdc_regs.vh ***
// constants for the x86 decode dispatch classifier
//--------------------------------------------------------------------
// Notes on behaviour
//--------------------------------------------------------------------
// Notes on behaviour
// [RULE_01] per clock: two short, one long, or one vector
// [RULE_02] any two short instructions pair together
// [RULE_03] packed media short except exit and cache_line_a
// [RULE_04] modrm top bits 11 register, else memory
// [RULE_05] register from bits 5:3 unless opcode encodes
// [RULE_06] media: second register bits 2:0, first 5:3
// [RULE_07] all loads to load unit, stores to store
// [RULE_08] plain alu goes to X or Y
// [RULE_09] X-restricted alu only to unit X
// [RULE_10] branch, float, media, load-immediate to own units
// [RULE_11] one chain unless defined as two chains
// [RULE_12] add/and memory destination long: load alu store
// [RULE_13] immediate group: 000 add, 010 adc, 100 and
// [RULE_14] every add-with-carry form is vector
// [RULE_15] add/and register destination memory source short
// [RULE_16] byte swap 0F C8..CF long single alu
// [RULE_17] near call short store; far/indirect call vector
// [RULE_18] 0F BA bits 5:3 select test/set/reset/complement
// [RULE_19] sign-extended imm8 add/and uses X alu
// [RULE_20] accumulator immediate add/and short
// [RULE_21] flag ops and clear task switched vector
// [RULE_22] vector goes to sequencer, nothing else decodes
`ifndef XDC_REGS_VH
`define XDC_REGS_VH

//--------------------------------------------------------------------
// decode classes
//--------------------------------------------------------------------
`define XDC_CLS_NONE   2'h0
`define XDC_CLS_SHORT  2'h1
`define XDC_CLS_LONG   2'h2
`define XDC_CLS_VECTOR 2'h3

//--------------------------------------------------------------------
// operation kinds (three 4-bit codes per slot)
//--------------------------------------------------------------------
`define XDC_OP_NONE    4'h0
`define XDC_OP_LOAD    4'h1
`define XDC_OP_STORE   4'h2
`define XDC_OP_ALU     4'h3
`define XDC_OP_ALUX    4'h4
`define XDC_OP_BRANCH  4'h5
`define XDC_OP_FLOAT   4'h6
`define XDC_OP_MEU     4'h7
`define XDC_OP_LIMM    4'h8

//--------------------------------------------------------------------
// execution unit codes
//--------------------------------------------------------------------
`define XDC_UNIT_NONE  3'h0
`define XDC_UNIT_LOAD  3'h1
`define XDC_UNIT_STORE 3'h2
`define XDC_UNIT_XY    3'h3
`define XDC_UNIT_X     3'h4
`define XDC_UNIT_BRU   3'h5
`define XDC_UNIT_FPU   3'h6
`define XDC_UNIT_MEU   3'h7
// load immediate stays in the instruction control unit: no unit code
`define XDC_UNIT_ICU   3'h0

//--------------------------------------------------------------------
// modrm field positions and encodings
//--------------------------------------------------------------------
`define XDC_MOD_HI     7
`define XDC_MOD_LO     6
`define XDC_REG_HI     5
`define XDC_REG_LO     3
`define XDC_RM_HI      2
`define XDC_RM_LO      0
`define XDC_MOD_REG    2'h3
`define XDC_GRP_ADD    3'h0
`define XDC_GRP_ADC    3'h2
`define XDC_GRP_AND    3'h4
`define XDC_BT_TEST    3'h4
`define XDC_BT_SET     3'h5
`define XDC_BT_RESET   3'h6
`define XDC_BT_COMPL   3'h7

//--------------------------------------------------------------------
// opcode bytes
//--------------------------------------------------------------------
`define XDC_OPC_ESC    8'h0F
`define XDC_OPC_BTIMM  8'hBA
`define XDC_OPC_BYTE_SWAP  5'h19
`define XDC_OPC_GRP80  8'h80
`define XDC_OPC_GRP81  8'h81
`define XDC_OPC_GRP83  8'h83
`define XDC_OPC_CALLN  8'hE8
`define XDC_OPC_CALLF  8'h9A
`define XDC_OPC_GRPFF  8'hFF
`define XDC_OPC_CLC    8'hF8
`define XDC_OPC_CLD    8'hFC
`define XDC_OPC_CLI    8'hFA
`define XDC_OPC_CMC    8'hF5
`define XDC_OPC_CLEAR_TASK_SWITCHED   8'h06
`define XDC_OPC_MULTIMEDIA_STATE_EXIT   8'h77
`define XDC_OPC_FAST_MULTIMEDIA_STATE_EXIT  8'h0E
`define XDC_OPC_PREF   8'h0D

`endif

// *** verilog/xdc_classifier.v ***
// decode classifier, operand picker and dispatcher for two decode slots
`timescale 1ns/1ns
`include "xdc_regs.vh"

module xdc_classifier (
	// clock and reset
	input  wire        clk_i,
	input  wire        rst_n_i,
	// slot a (older instruction)
	input  wire        a_valid_i,
	input  wire        a_esc_i,
	input  wire [7:0]  a_opc_i,
	input  wire [7:0]  a_modrm_i,
	input  wire        a_media_i,
	// slot b (younger instruction)
	input  wire        b_valid_i,
	input  wire        b_esc_i,
	input  wire [7:0]  b_opc_i,
	input  wire [7:0]  b_modrm_i,
	input  wire        b_media_i,
	// sequencer handshake
	input  wire        seq_done_i,
	// acceptance
	output reg  [1:0]  take_cnt_o,
	output reg         seq_start_o,
	output reg         seq_busy_o,
	// slot a results
	output reg  [1:0]  a_cls_o,
	output reg         a_mem_o,
	output reg  [2:0]  a_reg1_o,
	output reg  [2:0]  a_reg2_o,
	output reg  [11:0] a_ops_o,
	output reg  [8:0]  a_units_o,
	output reg         a_two_chain_o,
	output reg  [1:0]  a_bt_kind_o,
	// slot b results
	output reg  [1:0]  b_cls_o,
	output reg         b_mem_o,
	output reg  [2:0]  b_reg1_o,
	output reg  [2:0]  b_reg2_o,
	output reg  [11:0] b_ops_o,
	output reg  [8:0]  b_units_o
);

	//----------------------------------------------------------------
	// per-slot classification function
	//----------------------------------------------------------------
	// returns {two_chain, bt_kind[1:0], units[8:0], ops[11:0], reg2, reg1, mem, cls}
	function [32:0] xdc_decode;
		input       esc;
		input [7:0] opc;
		input [7:0] mrm;
		input       media;
		reg   [1:0] cls;
		reg         mem;
		reg   [2:0] r1;
		reg   [2:0] r2;
		reg   [3:0] o0;
		reg   [3:0] o1;
		reg   [3:0] o2;
		reg   [3:0] alu_k;
		reg   [1:0] btk;
		reg         two;
		reg   [2:0] gsel;
		begin
			cls   = `XDC_CLS_VECTOR;
			mem   = (mrm[`XDC_MOD_HI:`XDC_MOD_LO] != `XDC_MOD_REG); // see [RULE_04]
			r1    = mrm[`XDC_REG_HI:`XDC_REG_LO]; // see [RULE_05]
			r2    = mrm[`XDC_RM_HI:`XDC_RM_LO];
			o0    = `XDC_OP_NONE;
			o1    = `XDC_OP_NONE;
			o2    = `XDC_OP_NONE;
			btk   = 2'h0;
			two   = 1'b0; // see [RULE_11]
			gsel  = mrm[`XDC_REG_HI:`XDC_REG_LO];
			// byte forms use the X-only alu, wider forms either alu
			alu_k = opc[0] ? `XDC_OP_ALU : `XDC_OP_ALUX;
			if (media) begin
				// packed media short except state exits and cache_line_a
				if (esc && (opc == `XDC_OPC_MULTIMEDIA_STATE_EXIT || opc == `XDC_OPC_FAST_MULTIMEDIA_STATE_EXIT ||
						opc == `XDC_OPC_PREF)) begin
					cls = `XDC_CLS_VECTOR; // see [RULE_03]
				end else begin
					cls = `XDC_CLS_SHORT; // see [RULE_03]
					r2  = mrm[`XDC_RM_HI:`XDC_RM_LO]; // see [RULE_06]
					if (mem) begin
						o0 = `XDC_OP_LOAD;
						o1 = `XDC_OP_MEU;
					end else begin
						o0 = `XDC_OP_MEU;
					end
				end
			end else if (esc) begin
				if (opc[7:3] == `XDC_OPC_BYTE_SWAP) begin
					cls = `XDC_CLS_LONG; // see [RULE_16]
					r1  = opc[2:0]; // see [RULE_05]
					o0  = `XDC_OP_ALU;
				end else if (opc == `XDC_OPC_BTIMM) begin
					cls = `XDC_CLS_VECTOR; // see [RULE_18]
					btk = gsel[1:0];
				end else if (opc[7:4] == 4'h8) begin
					cls = `XDC_CLS_SHORT; // near conditional branch
					o0  = `XDC_OP_BRANCH;
				end else begin
					cls = `XDC_CLS_VECTOR; // see [RULE_21]
				end
			end else if ((opc[7:6] == 2'h0) && (opc[5:3] == 3'h0 || opc[5:3] == 3'h4) &&
					(opc[2:1] != 2'h3)) begin
				// add (00-05) and logical-and (20-25)
				if (opc[2]) begin
					cls = `XDC_CLS_SHORT; // see [RULE_20]
					o0  = alu_k;
				end else if (!mem) begin
					cls = `XDC_CLS_SHORT;
					o0  = alu_k; // see [RULE_09]
				end else if (!opc[1]) begin
					cls = `XDC_CLS_LONG; // see [RULE_12]
					o0  = `XDC_OP_LOAD;
					o1  = alu_k;
					o2  = `XDC_OP_STORE;
				end else begin
					cls = `XDC_CLS_SHORT; // see [RULE_15]
					o0  = `XDC_OP_LOAD;
					o1  = alu_k;
				end
			end else if (opc[7:3] == 5'h02) begin
				cls = `XDC_CLS_VECTOR; // see [RULE_14]
			end else if (opc == `XDC_OPC_GRP80 || opc == `XDC_OPC_GRP81 ||
					opc == `XDC_OPC_GRP83) begin
				if (gsel == `XDC_GRP_ADD || gsel == `XDC_GRP_AND) begin // see [RULE_13]
					if (opc == `XDC_OPC_GRP83)
						alu_k = `XDC_OP_ALUX; // see [RULE_19]
					if (mem) begin
						cls = `XDC_CLS_LONG;
						o0  = `XDC_OP_LOAD;
						o1  = alu_k;
						o2  = `XDC_OP_STORE;
					end else begin
						cls = `XDC_CLS_SHORT;
						o0  = alu_k;
					end
				end else begin
					cls = `XDC_CLS_VECTOR; // see [RULE_14]
				end
			end else if (opc == `XDC_OPC_CALLN) begin
				cls = `XDC_CLS_SHORT; // see [RULE_17]
				o0  = `XDC_OP_STORE;
			end else if (opc[7:4] == 4'h7 || opc == 8'hEB || opc == 8'hE9) begin
				cls = `XDC_CLS_SHORT;
				o0  = `XDC_OP_BRANCH; // see [RULE_10]
			end else if (opc[7:4] == 4'h4) begin
				cls = `XDC_CLS_SHORT;
				r1  = opc[2:0]; // see [RULE_05]
				o0  = `XDC_OP_ALU;
			end else begin
				// far/indirect call, flag ops and unlisted bytes go vector
				cls = `XDC_CLS_VECTOR; // see [RULE_17] see [RULE_21]
			end
			xdc_decode = {two, btk, unit_of(o2), unit_of(o1), unit_of(o0),
				o2, o1, o0, r2, r1, mem, cls};
		end
	endfunction

	// map an operation kind to the unit that executes it
	function [2:0] unit_of;
		input [3:0] op;
		begin
			case (op)
				`XDC_OP_LOAD:   unit_of = `XDC_UNIT_LOAD;  // see [RULE_07]
				`XDC_OP_STORE:  unit_of = `XDC_UNIT_STORE; // see [RULE_07]
				`XDC_OP_ALU:    unit_of = `XDC_UNIT_XY;    // see [RULE_08]
				`XDC_OP_ALUX:   unit_of = `XDC_UNIT_X;     // see [RULE_09]
				`XDC_OP_BRANCH: unit_of = `XDC_UNIT_BRU;   // see [RULE_10]
				`XDC_OP_FLOAT:  unit_of = `XDC_UNIT_FPU;
				`XDC_OP_MEU:    unit_of = `XDC_UNIT_MEU;
				default:        unit_of = `XDC_UNIT_ICU;
			endcase
		end
	endfunction

	//----------------------------------------------------------------
	// combinational decode of both slots
	//----------------------------------------------------------------
	wire [32:0] dec_a = xdc_decode(a_esc_i, a_opc_i, a_modrm_i, a_media_i);
	wire [32:0] dec_b = xdc_decode(b_esc_i, b_opc_i, b_modrm_i, b_media_i);
	// sequencer owns decode while set; declared here, ahead of its first reader
	reg         seq_busy_ff;
	wire        a_short = a_valid_i && (dec_a[1:0] == `XDC_CLS_SHORT);
	wire        a_vec   = a_valid_i && (dec_a[1:0] == `XDC_CLS_VECTOR);
	wire        b_short = b_valid_i && (dec_b[1:0] == `XDC_CLS_SHORT);

	//----------------------------------------------------------------
	// acceptance: slot b only pairs when both are short
	//----------------------------------------------------------------
	reg  [1:0] nxt_take;
	reg        nxt_start;
	always @* begin
		nxt_take  = 2'h0;
		nxt_start = 1'b0;
		// while the sequencer streams, nothing else decodes
		if (!seq_busy_ff && a_valid_i) begin // see [RULE_22]
			if (a_short && b_short)
				nxt_take = 2'h2; // see [RULE_01] see [RULE_02]
			else
				nxt_take = 2'h1; // see [RULE_01]
			nxt_start = a_vec; // see [RULE_22]
		end
	end

	//----------------------------------------------------------------
	// sequencer busy tracking
	//----------------------------------------------------------------
	always @(posedge clk_i) begin
		if (!rst_n_i)
			seq_busy_ff <= 1'b0;
		else if (nxt_start)
			seq_busy_ff <= 1'b1;
		else if (seq_done_i)
			seq_busy_ff <= 1'b0;
	end

	//----------------------------------------------------------------
	// registered outputs; unaccepted slots read as empty
	//----------------------------------------------------------------
	wire a_go = (nxt_take != 2'h0);
	wire b_go = (nxt_take == 2'h2);
	always @(posedge clk_i) begin
		if (!rst_n_i) begin
			take_cnt_o    <= 2'h0;
			seq_start_o   <= 1'b0;
			seq_busy_o    <= 1'b0;
			a_cls_o       <= `XDC_CLS_NONE;
			a_mem_o       <= 1'b0;
			a_reg1_o      <= 3'h0;
			a_reg2_o      <= 3'h0;
			a_ops_o       <= 12'h000;
			a_units_o     <= 9'h000;
			a_two_chain_o <= 1'b0;
			a_bt_kind_o   <= 2'h0;
			b_cls_o       <= `XDC_CLS_NONE;
			b_mem_o       <= 1'b0;
			b_reg1_o      <= 3'h0;
			b_reg2_o      <= 3'h0;
			b_ops_o       <= 12'h000;
			b_units_o     <= 9'h000;
		end else begin
			take_cnt_o    <= nxt_take;
			seq_start_o   <= nxt_start;
			seq_busy_o    <= nxt_start | (seq_busy_ff & ~seq_done_i);
			a_cls_o       <= a_go ? dec_a[1:0] : `XDC_CLS_NONE;
			a_mem_o       <= a_go & dec_a[2];
			a_reg1_o      <= a_go ? dec_a[5:3] : 3'h0;
			a_reg2_o      <= a_go ? dec_a[8:6] : 3'h0;
			a_ops_o       <= a_go ? dec_a[20:9] : 12'h000;
			a_units_o     <= a_go ? dec_a[29:21] : 9'h000;
			a_two_chain_o <= a_go & dec_a[32];
			a_bt_kind_o   <= a_go ? dec_a[31:30] : 2'h0; // see [RULE_18]
			b_cls_o       <= b_go ? dec_b[1:0] : `XDC_CLS_NONE;
			b_mem_o       <= b_go & dec_b[2];
			b_reg1_o      <= b_go ? dec_b[5:3] : 3'h0;
			b_reg2_o      <= b_go ? dec_b[8:6] : 3'h0;
			b_ops_o       <= b_go ? dec_b[20:9] : 12'h000;
			b_units_o     <= b_go ? dec_b[29:21] : 9'h000;
		end
	end

endmodule

// *** dv/xdc_props.sv ***
// concurrent checks on the decode classifier ports
`timescale 1ns/1ns
`include "xdc_regs.vh"
module xdc_props (
	// clock and reset
	input wire logic        clk_i,
	input wire logic        rst_n_i,
	// slot a request and sequencer
	input wire logic        a_esc_i,
	input wire logic [7:0]  a_opc_i,
	input wire logic [7:0]  a_modrm_i,
	input wire logic        a_media_i,
	input wire logic        seq_done_i,
	// results
	input wire logic [1:0]  take_cnt_o,
	input wire logic        seq_start_o,
	input wire logic        seq_busy_o,
	input wire logic [1:0]  a_cls_o,
	input wire logic [1:0]  b_cls_o,
	input wire logic        a_mem_o,
	input wire logic [2:0]  a_reg1_o,
	input wire logic [11:0] a_ops_o,
	input wire logic [8:0]  a_units_o
);
	//------------------------------------------------------------
	// properties
	//------------------------------------------------------------
	default clocking @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);
	// unit codes follow op codes; load immediate has no unit
	function automatic bit map_ok(input logic [11:0] p, input logic [8:0] u);
		map_ok = 1'b1;
		for (int i = 0; i < 3; i++)
			if (u[3*i +: 3] != ((p[4*i +: 4] == `XDC_OP_LIMM) ? 3'h0 : p[4*i +: 3])) map_ok = 1'b0;
	endfunction
	sequence s_took;
		take_cnt_o != 2'h0;
	endsequence
	sequence s_handoff;
		seq_start_o && seq_busy_o && take_cnt_o == 2'h1;
	endsequence
	a_take_limit: assert property (take_cnt_o != 2'h3)
		else $error("take count above two");
	a_pair_short: assert property (take_cnt_o == 2'h2 |-> a_cls_o == 2'h1 && b_cls_o == 2'h1)
		else $error("pair without two short");
	a_media_cls: assert property (s_took ##0 $past(a_media_i && a_esc_i) |->
		(a_cls_o == 2'h1) == !$past(a_opc_i == 8'h77 || a_opc_i == 8'h0E || a_opc_i == 8'h0D))
		else $error("media class wrong");
	a_mem_form: assert property (s_took ##0 $past(!a_esc_i && a_opc_i[7:2] == 6'h00) |->
		a_mem_o == ($past(a_modrm_i[7:6]) != 2'h3)) else $error("form select wrong");
	a_reg_opcode: assert property (s_took ##0 $past(!a_esc_i && a_opc_i[7:3] == 5'h08) |->
		a_reg1_o == $past(a_opc_i[2:0])) else $error("opcode register wrong");
	a_unit_map: assert property (map_ok(a_ops_o, a_units_o))
		else $error("unit routing wrong");
	a_adc_vector: assert property (s_took ##0
		$past(!a_esc_i && a_opc_i[7:3] == 5'h02 && a_opc_i[2:1] != 2'h3) |-> a_cls_o == 2'h3)
		else $error("carry add not vector");
	a_vec_handoff: assert property (s_took ##0 a_cls_o == 2'h3 |-> s_handoff ##1 !take_cnt_o)
		else $error("vector handoff wrong");
	a_busy_release: assert property (seq_busy_o && !seq_start_o && seq_done_i |=>
		!seq_busy_o || seq_start_o) else $error("busy not released");
	a_swap_long: assert property (s_took ##0 $past(a_esc_i && a_opc_i[7:3] == 5'h19) |->
		a_cls_o == 2'h2 && a_ops_o == 12'h003 && a_reg1_o == $past(a_opc_i[2:0]))
		else $error("byte swap decode wrong");
endmodule
bind xdc_classifier xdc_props xdc_props_inst (.*);

// *** dv/xdc_seq_model.sv ***
// vector sequencer model: answers each start after a chosen stream length
`timescale 1ns/1ns
module xdc_seq_model (
	// clock and reset
	input  wire logic clk_i,
	input  wire logic rst_n_i,
	// handshake
	input  wire logic seq_start_o,
	input  wire logic [31:0] lat,
	output logic      seq_done_i = 1'b0
);
	int cnt = -1;
	// done is one pulse; never in the start cycle, which the decoder would drop
	always @(posedge clk_i) begin
		seq_done_i <= 1'b0;
		if (!rst_n_i) cnt <= -1;
		else if (seq_start_o) cnt <= lat;
		else if (cnt == 0) begin
			seq_done_i <= 1'b1;
			cnt <= -1;
		end else if (cnt > 0) cnt <= cnt - 1;
	end
endmodule

// *** dv/x86_decode_dispatch_classifier_bench.sv ***
// self-checking bench for the decode classifier
`timescale 1ns/1ns
`include "xdc_regs.vh"
module x86_decode_dispatch_classifier_bench;
	logic        clk_i = 1'b0, rst_n_i = 1'b0, seq_done_i, seq_start_o, seq_busy_o;
	logic        a_valid_i = 1'b0, a_esc_i = 1'b0, a_media_i = 1'b0, a_mem_o, a_two_chain_o;
	logic        b_valid_i = 1'b0, b_esc_i = 1'b0, b_media_i = 1'b0, b_mem_o, e_hasm, e_rcod;
	logic [7:0]  a_opc_i = '0, a_modrm_i = '0, b_opc_i = '0, b_modrm_i = '0;
	logic [1:0]  take_cnt_o, a_cls_o, b_cls_o, a_bt_kind_o, e_cls;
	logic [2:0]  a_reg1_o, a_reg2_o, b_reg1_o, b_reg2_o;
	logic [11:0] a_ops_o, b_ops_o, e_ops;
	logic [8:0]  a_units_o, b_units_o;
	int          errors = 0, samples_checked = 0, lat = 0;
	// opcode mix as {escape, opcode}
	logic [8:0]  tbl [37] = '{9'h000, 9'h001, 9'h002, 9'h003, 9'h020, 9'h021, 9'h022, 9'h023,
		9'h004, 9'h005, 9'h024, 9'h025, 9'h010, 9'h011, 9'h012, 9'h013, 9'h014, 9'h015,
		9'h040, 9'h047, 9'h080, 9'h081, 9'h083, 9'h0E8, 9'h09A, 9'h0F8, 9'h0FC, 9'h0FA,
		9'h0F5, 9'h1C8, 9'h1CF, 9'h1BA, 9'h106, 9'h177, 9'h10E, 9'h10D, 9'h1FC};
	//------------------------------------------------------------
	// harness and reference model
	//------------------------------------------------------------
	always #2 clk_i = ~clk_i;
	xdc_classifier xdc_classifier_inst (.*);
	xdc_seq_model xdc_seq_model_inst (.clk_i(clk_i), .rst_n_i(rst_n_i),
		.seq_start_o(seq_start_o), .lat(lat), .seq_done_i(seq_done_i));
	function automatic logic md(input logic [8:0] x);
		md = x[8] && (x[7:0] == 8'h77 || x[7:0] == 8'h0E || x[7:0] == 8'h0D || x[7:0] == 8'hFC);
	endfunction
	// group opcodes only get the add, carry-add and and selectors
	function automatic logic [7:0] mk(input logic [8:0] o, input logic [7:0] r);
		mk = r;
		if (o[8:2] == 7'h20) mk[5:3] = {r[4] & ~r[3], r[3], 1'b0};
	endfunction
	function automatic logic [8:0] units(input logic [11:0] p);
		for (int i = 0; i < 3; i++) units[3*i +: 3] = (p[4*i +: 4] == 4'h8) ? 3'h0 : p[4*i +: 3];
	endfunction
	task automatic model(input logic [8:0] x, input logic [7:0] m);
		logic r, e;
		logic [3:0] al;
		r = (m[7:6] == 2'h3);
		e = !x[0] && x[1];
		al = x[0] ? `XDC_OP_ALU : `XDC_OP_ALUX;
		{e_cls, e_ops, e_hasm, e_rcod} = {`XDC_CLS_VECTOR, 12'h000, 2'b00};
		casez (x)
			9'b1_1100_1???: {e_cls, e_ops, e_rcod} = {`XDC_CLS_LONG, 12'h003, 1'b1};
			9'h1BA: e_hasm = 1'b1;
			9'b1_????_????: if (md(x) && x[7:0] == 8'hFC) begin
				{e_cls, e_hasm} = {`XDC_CLS_SHORT, 1'b1};
				e_ops = r ? {8'h00, `XDC_OP_MEU} : {4'h0, `XDC_OP_MEU, `XDC_OP_LOAD};
			end
			9'b0_00?0_00??: begin
				e_hasm = 1'b1;
				e_cls = (r || x[1]) ? `XDC_CLS_SHORT : `XDC_CLS_LONG;
				e_ops = r ? {8'h00, al} : {x[1] ? 4'h0 : `XDC_OP_STORE, al, `XDC_OP_LOAD};
			end
			9'b0_00?0_010?: {e_cls, e_ops} = {`XDC_CLS_SHORT, 8'h00, al};
			9'b0_0001_00??: e_hasm = 1'b1;
			9'b0_0100_0???: {e_cls, e_ops, e_rcod} = {`XDC_CLS_SHORT, 12'h003, 1'b1};
			9'b0_1000_00??: begin
				e_hasm = 1'b1;
				al = (x[1:0] == 2'h1) ? `XDC_OP_ALU : `XDC_OP_ALUX;
				if (m[5:3] != 3'h2) e_cls = r ? `XDC_CLS_SHORT : `XDC_CLS_LONG;
				if (m[5:3] != 3'h2) e_ops = r ? {8'h00, al} : {`XDC_OP_STORE, al, `XDC_OP_LOAD};
			end
			9'h0E8: {e_cls, e_ops} = {`XDC_CLS_SHORT, 12'h002};
			default: e_hasm = 1'b0;
		endcase
	endtask
	//------------------------------------------------------------
	// checking and driving
	//------------------------------------------------------------
	task automatic test_done();
		$display("comparisons %0d mismatches %0d", samples_checked, errors);
		if (errors == 0 && samples_checked > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic chk(input logic [11:0] got, input logic [11:0] exp);
		samples_checked++;
		if (got !== exp) begin
			errors++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic slot(input logic [1:0] c, input logic [11:0] p, input logic [8:0] u,
		input logic mm, input logic [2:0] r1, r2, input logic [8:0] x, input logic [7:0] m);
		model(x, m);
		chk(c, e_cls);
		if (e_cls != `XDC_CLS_VECTOR) chk(p, e_ops);
		if (e_cls != `XDC_CLS_VECTOR) chk(u, units(e_ops));
		if (e_hasm) chk({mm, r1, r2}, {m[7:6] != 2'h3, m[5:0]});
		if (e_rcod) chk(r1, x[2:0]);
	endtask
	// present a pair; a held vector re-presented while busy must be refused
	task automatic issue(input logic [8:0] a, b, input logic [7:0] am, bm);
		logic [1:0] et;
		lat = $urandom_range(6);
		@(posedge clk_i);
		{a_esc_i, a_opc_i, a_modrm_i, a_media_i, a_valid_i} <= {a, am, md(a), 1'b1};
		{b_esc_i, b_opc_i, b_modrm_i, b_media_i, b_valid_i} <= {b, bm, md(b), 1'b1};
		@(posedge clk_i);
		model(b, bm);
		et = (e_cls == `XDC_CLS_SHORT) ? 2'h2 : 2'h1;
		model(a, am);
		if (e_cls != `XDC_CLS_SHORT) et = 2'h1;
		a_valid_i <= (e_cls == `XDC_CLS_VECTOR && lat > 2);
		b_valid_i <= 1'b0;
		#1;
		chk(take_cnt_o, et);
		if (et == 2'h2) slot(b_cls_o, b_ops_o, b_units_o, b_mem_o, b_reg1_o, b_reg2_o, b, bm);
		slot(a_cls_o, a_ops_o, a_units_o, a_mem_o, a_reg1_o, a_reg2_o, a, am);
		if (a == 9'h1BA) chk(a_bt_kind_o, am[4:3]);
		chk(a_two_chain_o, 1'b0);
		if (e_cls == `XDC_CLS_VECTOR) begin
			chk(seq_start_o, 1'b1);
			for (int k = 0; k < 60 && seq_busy_o; k++) begin
				@(posedge clk_i);
				if (k == 1) a_valid_i <= 1'b0;
				#1;
				if (k < 2 && lat > 2) chk(take_cnt_o, 2'h0);
			end
			if (seq_busy_o) errors++;
			if (seq_busy_o) test_done();
		end
	endtask
	// main sequence: reset, every opcode in all four forms, then random pairs
	initial begin
		void'($urandom(32'h9093_2d11));
		repeat (3) @(posedge clk_i);
		rst_n_i <= 1'b1;
		#1;
		chk({take_cnt_o, a_cls_o, seq_busy_o}, 12'h000);
		issue(9'h000, 9'h001, 8'hC1, 8'hC0);
		foreach (tbl[i]) for (int j = 0; j < 4; j++)
			issue(tbl[i], 9'h003, mk(tbl[i], {2'(j), 3'(j + 4), 3'(7 - j)}), 8'hD5);
		$display("test opcode sweep done");
		repeat (300) issue(tbl[$urandom_range(36)], tbl[$urandom_range(36)],
			mk(9'h080, 8'($urandom)), mk(9'h080, 8'($urandom)));
		$display("test random pairs done");
		test_done();
	end
endmodule
